// File: core/tsp_consts.vh
// Purpose: constants for the timed serdes io port
// Assumes: 32-bit register port, byte addresses
// Notes: definitions only
`ifndef TSP_CONSTS_VH
`define TSP_CONSTS_VH
// register byte addresses
`define TSP_A_CTRL 8'H00
`define TSP_A_COND 8'H04
`define TSP_A_TIME 8'H08
`define TSP_A_DATA 8'H0C
`define TSP_A_COUNT 8'H10
`define TSP_A_TSTAMP 8'H14
`define TSP_A_STS 8'H18
`define TSP_A_MASK 8'H1C
`define TSP_A_CB1 8'H20
`define TSP_A_CB5 8'H30
// control fields
`define TSP_C_EN 0
`define TSP_C_DIR 1
`define TSP_C_OD 2
`define TSP_C_WLO 3
`define TSP_C_WHI 5
`define TSP_C_CLO 6
`define TSP_C_CHI 7
`define TSP_C_SIN 8
`define TSP_C_SOUT 9
`define TSP_C_SLO 10
`define TSP_C_SHI 12
`define TSP_CTRL_RST 13'H0000
// width codes
`define TSP_W1 3'H0
`define TSP_W4 3'H1
`define TSP_W8 3'H2
`define TSP_W16 3'H3
`define TSP_W32 3'H4
// condition modes
`define TSP_CM_NONE 2'H0
`define TSP_CM_EQ 2'H1
`define TSP_CM_NE 2'H2
// status bits
`define TSP_S_DONE 0
`define TSP_S_OVR 1
`define TSP_S_COND 2
// clock block config fields
`define TSP_CB_DLO 0
`define TSP_CB_DHI 7
`define TSP_CB_SRC 8
`define TSP_NCB 6
`define TSP_CB0 3'H0
`endif

// File: core/tsp_clkblk.v
// Purpose: six clock blocks producing port clock enables
// Assumes: ext_clk_pin is synchronous to clk
// Notes: block 0 ticks every cycle (tile reference)
`timescale 1ns/1ns
`include "tsp_consts.vh"
module tsp_clkblk (
    // clock and reset
    input wire clk,
    input wire rst,
    // configuration for blocks 1..5
    input wire [39:0] div_cfg,
    input wire [4:0] src_ext,
    // 1-bit port pin used as external clock
    input wire ext_clk_pin,
    // one tick per block
    output reg [5:0] tick_r
);
    reg ext_d_r; // previous pin level
    reg [7:0] cnt_r [1:5]; // divider counters
    wire ext_rise; // rising edge of external clock
    integer i;

    assign ext_rise = ext_clk_pin & ~ext_d_r;

    // edge detect and dividers; divisor n ticks every n+1 source edges
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_d_r <= 1'B0;
            tick_r <= 6'H00;
            for (i = 1; i < 6; i = i + 1) begin
                cnt_r[i] <= 8'H00;
            end
        end else begin
            ext_d_r <= ext_clk_pin;
            tick_r[0] <= 1'B1;
            for (i = 1; i < 6; i = i + 1) begin
                // source is the reference or the pin edge
                if (src_ext[i-1] ? ext_rise : 1'B1) begin
                    if (cnt_r[i] >= div_cfg[(i-1)*8 +: 8]) begin
                        cnt_r[i] <= 8'H00;
                        tick_r[i] <= 1'B1;
                    end else begin
                        cnt_r[i] <= cnt_r[i] + 8'H01;
                        tick_r[i] <= 1'B0;
                    end
                end else begin
                    tick_r[i] <= 1'B0;
                end
            end
        end
    end
endmodule

// File: core/tsp_port.v
// Purpose: one timed serdes io port with register access
// Assumes: pin inputs synchronous to clk; one narrower-port claim mask
// Notes: port bit k maps to pin k; transfer register plus serdes
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`include "tsp_consts.vh"
module tsp_port (
    // clock and reset
    input wire clk,
    input wire rst,
    // register port
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output reg [31:0] rdata_r,
    // pins
    input wire [31:0] pin_in,
    output reg [31:0] pin_out_r,
    output reg [31:0] pin_oe_r,
    input wire input_strobe,
    output reg output_strobe_r,
    // sharing
    input wire link_en,
    input wire [31:0] pin_taken,
    input wire ext_clk_pin,
    // events and interrupt
    output reg event_r,
    output reg irq_r
);
    // width decode helpers
    function [5:0] wbits;
        input [2:0] code;
        begin
            case (code)
                `TSP_W1: wbits = 6'H01;
                `TSP_W4: wbits = 6'H04;
                `TSP_W8: wbits = 6'H08;
                `TSP_W16: wbits = 6'H10;
                default: wbits = 6'H20;
            endcase
        end
    endfunction

    function [31:0] wmask;
        input [2:0] code;
        begin
            case (code)
                `TSP_W1: wmask = 32'H00000001;
                `TSP_W4: wmask = 32'H0000000F;
                `TSP_W8: wmask = 32'H000000FF;
                `TSP_W16: wmask = 32'H0000FFFF;
                default: wmask = 32'HFFFFFFFF;
            endcase
        end
    endfunction

    // slices per word minus one
    function [4:0] slices;
        input [2:0] code;
        begin
            case (code)
                `TSP_W1: slices = 5'H1F;
                `TSP_W4: slices = 5'H07;
                `TSP_W8: slices = 5'H03;
                `TSP_W16: slices = 5'H01;
                default: slices = 5'H00;
            endcase
        end
    endfunction

    // registers
    reg [12:0] ctrl_r; // control
    reg [31:0] cond_r; // condition value
    reg [15:0] time_r; // timed transfer count
    reg time_arm_r; // timed transfer pending
    reg [15:0] count_r; // port counter
    reg [15:0] tstamp_r; // last transfer time
    reg [31:0] xfer_r; // transfer register
    reg xfer_full_r; // transfer register holds data
    reg [31:0] sr_r; // serdes shift register
    reg [4:0] scnt_r; // slices left
    reg busy_r; // serdes mid-word
    reg [2:0] sts_r; // sticky status
    reg [2:0] mask_r; // interrupt mask
    reg [39:0] cb_div_r; // clock block divisors
    reg [4:0] cb_src_r; // clock block sources

    wire [5:0] ticks; // clock block enables
    wire [2:0] wcode; // width code
    wire [5:0] w; // width in bits
    wire [31:0] m; // width mask
    wire en; // port enabled
    wire dir_out; // port drives pins
    wire tick; // selected port clock
    wire [31:0] sample; // usable pin bits
    wire cond_ok; // start condition met
    wire time_ok; // timed transfer allowed
    wire rx_go; // input slice taken
    wire [31:0] rx_word; // assembled input
    wire tx_load; // output word loaded
    wire tx_drive; // a slice goes out
    wire [31:0] tx_slice; // slice to drive
    wire done; // word transferred
    wire wr_data; // software writes data
    wire rd_data; // software reads data
    wire ovr; // overrun or overwrite
    wire [2:0] cbi; // clock block index
    wire [2:0] sel; // port clock block
    wire [31:0] od_oe; // open-drain enables: zero bits pulled, one bits released

    assign wcode = ctrl_r[`TSP_C_WHI:`TSP_C_WLO];
    assign w = wbits(wcode);
    assign m = wmask(wcode);
    assign en = ctrl_r[`TSP_C_EN];
    assign dir_out = ctrl_r[`TSP_C_DIR];
    assign sel = (ctrl_r[`TSP_C_SHI:`TSP_C_SLO] < `TSP_NCB) ? ctrl_r[`TSP_C_SHI:`TSP_C_SLO] : `TSP_CB0;
    assign tick = ticks[sel] & en;

    // taken or link-owned pins read as zero, word stays full width
    // software cannot tell a taken pin from a low one; it must know the claim map
    assign sample = pin_in & ~pin_taken & m & {32{~link_en}};

    // condition on the sampled slice
    assign cond_ok = (ctrl_r[`TSP_C_CHI:`TSP_C_CLO] == `TSP_CM_EQ) ? (sample == (cond_r & m)) :
                     (ctrl_r[`TSP_C_CHI:`TSP_C_CLO] == `TSP_CM_NE) ? (sample != (cond_r & m)) :
                     1'B1;
    // full-width compare: a target already passed waits a whole counter wrap
    assign time_ok = ~time_arm_r | (count_r == time_r);

    // input: strobe qualifies each sample; first slice also waits on condition and time
    assign rx_go = tick & ~dir_out & (~ctrl_r[`TSP_C_SIN] | input_strobe) &
                   (busy_r | (cond_ok & time_ok));
    assign rx_word = (sr_r >> w) | (sample << (6'H20 - w));

    // output: load from transfer register when idle
    // a timed word waits in the transfer register until its count comes round
    assign tx_load = tick & dir_out & ~busy_r & xfer_full_r & time_ok;
    assign tx_drive = tick & dir_out & (busy_r | tx_load);
    assign tx_slice = (busy_r ? sr_r : xfer_r) & m;

    assign done = (rx_go & (busy_r ? (scnt_r == 5'H00) : (slices(wcode) == 5'H00))) | tx_load;
    assign wr_data = wr & (addr == `TSP_A_DATA) & dir_out;
    assign rd_data = rd & (addr == `TSP_A_DATA) & ~dir_out;
    assign ovr = (done & ~dir_out & xfer_full_r & ~rd_data) | (wr_data & xfer_full_r & ~tx_load);
    // clock block window word k configures block k+1
    assign cbi = addr[4:2];

    // open drain enables only the zero bits of a slice, holds them between
    // slow port clocks and releases every pin once the word has gone out
    assign od_oe = tx_drive ? ~tx_slice : (busy_r ? pin_oe_r : 32'H00000000);

    tsp_clkblk u_clkblk (
        .clk(clk),
        .rst(rst),
        .div_cfg(cb_div_r),
        .src_ext(cb_src_r),
        .ext_clk_pin(ext_clk_pin),
        .tick_r(ticks)
    );

    // register writes, single cycle
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= `TSP_CTRL_RST;
            cond_r <= 32'H00000000;
            time_r <= 16'H0000;
            mask_r <= 3'H0;
            cb_div_r <= 40'H0000000000;
            cb_src_r <= 5'H00;
        end else if (wr) begin
            case (addr)
                `TSP_A_CTRL: ctrl_r <= wdata[12:0];
                `TSP_A_COND: cond_r <= wdata;
                `TSP_A_TIME: time_r <= wdata[15:0];
                `TSP_A_MASK: mask_r <= wdata[2:0];
                default: begin
                    // clock blocks 1..5
                    if (addr >= `TSP_A_CB1 && addr <= `TSP_A_CB5 && addr[1:0] == 2'H0) begin
                        // window word number is the divider slot, no offset
                        cb_div_r[cbi * 8 +: 8] <= wdata[`TSP_CB_DHI:`TSP_CB_DLO];
                        cb_src_r[cbi] <= wdata[`TSP_CB_SRC];
                    end
                end
            endcase
        end
    end

    // counter, timestamp and timed arm
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            count_r <= 16'H0000;
            tstamp_r <= 16'H0000;
            time_arm_r <= 1'B0;
        end else begin
            // frozen while disabled, so a stopped port keeps its last time
            if (tick) begin
                count_r <= count_r + 16'H0001;
            end
            // stamp is the count of the completing tick itself
            if (done) begin
                tstamp_r <= count_r;
            end
            // a write arms; the first slice of a word disarms
            if (wr & (addr == `TSP_A_TIME)) begin
                time_arm_r <= 1'B1;
            end else if (tx_load | (rx_go & ~busy_r)) begin
                time_arm_r <= 1'B0;
            end
        end
    end

    // serdes and transfer register
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sr_r <= 32'H00000000;
            scnt_r <= 5'H00;
            busy_r <= 1'B0;
            xfer_r <= 32'H00000000;
            xfer_full_r <= 1'B0;
        end else begin
            if (~en) begin
                // disabling drops a partial word
                // software never sees a half-shifted word, at the cost of its slices
                busy_r <= 1'B0;
            end else if (rx_go) begin
                sr_r <= rx_word;
                if (busy_r) begin
                    scnt_r <= scnt_r - 5'H01;
                    busy_r <= (scnt_r != 5'H00);
                end else begin
                    scnt_r <= slices(wcode) - 5'H01;
                    busy_r <= (slices(wcode) != 5'H00);
                end
            end else if (tx_drive) begin
                sr_r <= (busy_r ? sr_r : xfer_r) >> w;
                if (busy_r) begin
                    scnt_r <= scnt_r - 5'H01;
                    busy_r <= (scnt_r != 5'H01) & (scnt_r != 5'H00);
                end else begin
                    scnt_r <= slices(wcode);
                    busy_r <= (slices(wcode) != 5'H00);
                end
            end
            // completion and software fill win over a read or a load
            if (done & ~dir_out) begin
                xfer_r <= rx_word;
                xfer_full_r <= 1'B1;
            end else if (wr_data) begin
                xfer_r <= wdata;
                xfer_full_r <= 1'B1;
            end else if (rd_data | tx_load) begin
                xfer_full_r <= 1'B0;
            end
        end
    end

    // pin drivers and output strobe
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_out_r <= 32'H00000000;
            pin_oe_r <= 32'H00000000;
            output_strobe_r <= 1'B0;
        end else begin
            if (tx_drive) begin
                // open drain never drives a one
                pin_out_r <= ctrl_r[`TSP_C_OD] ? 32'H00000000 : tx_slice;
            end
            if (en & dir_out & ~link_en) begin
                // narrower ports keep their pins
                pin_oe_r <= m & ~pin_taken & (ctrl_r[`TSP_C_OD] ? od_oe : m);
            end else begin
                pin_oe_r <= 32'H00000000;
            end
            if (tick) begin
                output_strobe_r <= tx_drive & ctrl_r[`TSP_C_SOUT];
            end
        end
    end

    // status, events, interrupt
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sts_r <= 3'H0;
            event_r <= 1'B0;
            irq_r <= 1'B0;
        end else begin
            // set wins over write-one-to-clear
            // so an event landing beside a clear of the same bit is never lost
            sts_r <= (sts_r & ~((wr && addr == `TSP_A_STS) ? wdata[2:0] : 3'H0)) |
                     {rx_go & ~busy_r & (ctrl_r[`TSP_C_CHI:`TSP_C_CLO] != `TSP_CM_NONE), ovr, done};
            event_r <= done | (rx_go & ~busy_r & (ctrl_r[`TSP_C_CHI:`TSP_C_CLO] != `TSP_CM_NONE));
            irq_r <= |(sts_r & mask_r);
        end
    end

    // read data, one cycle after the strobe
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_r <= 32'H00000000;
        end else if (rd) begin
            case (addr)
                `TSP_A_CTRL: rdata_r <= {19'H00000, ctrl_r};
                `TSP_A_COND: rdata_r <= cond_r;
                `TSP_A_TIME: rdata_r <= {16'H0000, time_r};
                `TSP_A_DATA: rdata_r <= xfer_r;
                `TSP_A_COUNT: rdata_r <= {16'H0000, count_r};
                `TSP_A_TSTAMP: rdata_r <= {16'H0000, tstamp_r};
                `TSP_A_STS: rdata_r <= {27'H0000000, busy_r, xfer_full_r, sts_r};
                `TSP_A_MASK: rdata_r <= {29'H00000000, mask_r};
                default: begin
                    if (addr >= `TSP_A_CB1 && addr <= `TSP_A_CB5 && addr[1:0] == 2'H0) begin
                        // same window layout as the write side
                        rdata_r <= {23'H000000, cb_src_r[cbi], cb_div_r[cbi * 8 +: 8]};
                    end else begin
                        rdata_r <= 32'H00000000;
                    end
                end
            endcase
        end else begin
            rdata_r <= 32'H00000000;
        end
    end
endmodule

// File: dv/tsp_port_asserts.sv
// Purpose: port-level checks for tsp_port
// Assumes: one clk domain, rst async active high
// Notes: sees top ports only, bound from the bench
`timescale 1ns/1ns
`include "tsp_consts.vh"
module tsp_port_chk (
    // clock and reset
    input wire clk,
    input wire rst,
    // register port
    input wire [7:0] addr,
    input wire wr,
    input wire rd,
    input wire [31:0] rdata_r,
    // pins and sharing
    input wire [31:0] pin_oe_r,
    input wire [31:0] pin_taken,
    input wire link_en,
    input wire output_strobe_r,
    input wire event_r,
    input wire irq_r
);
    // last read word, so two count reads can be compared
    reg [15:0] prev_r;
    wire [15:0] cnt_step = rdata_r[15:0] - prev_r;
    always @(posedge clk) begin
        prev_r <= rdata_r[15:0];
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // a counter read, then a second one right behind it
    sequence s_cnt_rd;
        rd && addr == `TSP_A_COUNT;
    endsequence
    sequence s_cnt_pair;
        s_cnt_rd ##1 s_cnt_rd;
    endsequence
    a_rdata_after_read: assert property (rdata_r != 32'H0 |-> $past(rd))
        else $error("read data outside answer cycle");
    a_unmapped_read_zero: assert property ($past(rd) && $past(addr) > `TSP_A_CB5 |-> rdata_r == 32'H0)
        else $error("unmapped read not zero");
    a_link_blocks_drive: assert property (link_en && $past(link_en) |-> pin_oe_r == 32'H0)
        else $error("pins driven while link owns them");
    a_taken_blocks_drive: assert property ((pin_oe_r & pin_taken & $past(pin_taken)) == 32'H0)
        else $error("claimed pin still driven");
    a_reset_leaves_quiet: assert property ($fell(rst) |-> pin_oe_r == 32'H0 && !event_r && !irq_r && !output_strobe_r)
        else $error("outputs busy right after reset");
    a_irq_clear_write: assert property ($fell(irq_r) |-> $past(wr) || $past(wr, 2))
        else $error("irq dropped without a write");
    a_count_one_step: assert property (s_cnt_pair |=> cnt_step <= 16'H0001)
        else $error("counter moved more than one per clock");
    a_count_sixteen_bit: assert property ($past(rd) && $past(addr) == `TSP_A_COUNT |-> rdata_r[31:16] == 16'H0)
        else $error("counter wider than 16 bits");
endmodule

// File: dv/tsp_pins_model.sv
// Purpose: hardware attached to the port pins
// Assumes: pins carry pull-downs
// Notes: port drive wins over the outside driver
`timescale 1ns/1ns
module tsp_pins_model (
    // port side
    input wire [31:0] pin_out_r,
    input wire [31:0] pin_oe_r,
    // outside hardware
    input wire [31:0] drv_val,
    input wire [31:0] drv_en,
    input wire drv_strobe,
    // levels seen by the port
    output wire [31:0] pin_in,
    output wire input_strobe
);
    // undriven lines fall to the pull-down, never hold a stale level
    assign pin_in = (pin_oe_r & pin_out_r) | (~pin_oe_r & drv_en & drv_val);
    // strobe qualifying incoming data
    assign input_strobe = drv_strobe;
endmodule

// File: dv/tb_timed_serdes_io_port.sv
// Purpose: self-checking bench for tsp_port
// Assumes: 25 MHz clk, reset held 12 cycles
// Notes: one task per scenario
`timescale 1ns/1ns
`include "tsp_consts.vh"
module tb_timed_serdes_io_port;
    // clock, reset, register port
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg [7:0] addr = 8'H00;
    reg [31:0] wdata = 32'H0;
    reg wr = 1'b0;
    reg rd = 1'b0;
    // sharing and outside hardware
    reg link_en = 1'b0;
    reg [31:0] pin_taken = 32'H0;
    reg [31:0] drv_val = 32'H0;
    reg [31:0] drv_en = 32'H0;
    reg drv_strobe = 1'b0;
    reg ext_clk = 1'b0;
    wire [31:0] rdata_r, pin_out_r, pin_oe_r, pin_in;
    wire input_strobe, output_strobe_r, event_r, irq_r;
    integer miscompares = 0;
    integer checks_done = 0;
    integer n;
    integer i;
    reg [31:0] v, u;
    always #20 clk = ~clk;
    // ext_clk stands in for the 1-bit clock port, toggled only by t_ext
    tsp_port tsp_port_inst (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata_r(rdata_r), .pin_in(pin_in), .pin_out_r(pin_out_r), .pin_oe_r(pin_oe_r),
        .input_strobe(input_strobe), .output_strobe_r(output_strobe_r), .link_en(link_en),
        .pin_taken(pin_taken), .ext_clk_pin(ext_clk), .event_r(event_r), .irq_r(irq_r));
    tsp_pins_model tsp_pins_model_inst (.pin_out_r(pin_out_r), .pin_oe_r(pin_oe_r), .drv_val(drv_val),
        .drv_en(drv_en), .drv_strobe(drv_strobe), .pin_in(pin_in), .input_strobe(input_strobe));
    task test_done;
        begin
            if (miscompares == 0 && checks_done > 0) begin
                $display("SIMULATION PASSED");
            end else begin
                $display("SIMULATION FAILED");
            end
            $finish;
        end
    endtask
    task check(input string what, input [31:0] seen, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("unexpected %0s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task wr_reg(input [7:0] a, input [31:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
        end
    endtask
    task rd_reg(input [7:0] a, output [31:0] d);
        begin
            @(posedge clk);
            addr <= a;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            #1 d = rdata_r;
        end
    endtask
    // two counter reads back to back into v and u
    task rd2;
        begin
            @(posedge clk);
            addr <= `TSP_A_COUNT;
            rd <= 1'b1;
            @(posedge clk);
            #1 v = rdata_r;
            @(posedge clk);
            rd <= 1'b0;
            #1 u = rdata_r;
        end
    endtask
    // bounded wait for the port event, n holds cycles waited
    task wait_evt(input integer lim);
        begin
            n = 0;
            @(posedge clk);
            #1;
            while (event_r !== 1'b1 && n < lim) begin
                @(posedge clk);
                #1;
                n = n + 1;
            end
            if (n >= lim) begin
                miscompares = miscompares + 1;
                test_done;
            end
        end
    endtask
    task t_reset;
        begin
            rd_reg(`TSP_A_CTRL, v);
            check("ctrl reset", v, 32'H0);
            rd_reg(8'H40, v);
            check("unmapped", v, 32'H0);
            check("oe reset", pin_oe_r, 32'H0);
            rd2;
            check("count idle", u, 32'H0);
        end
    endtask
    // spaced reads 8 clocks apart give ticks of the chosen block
    task t_rate(input [31:0] ctrl, input [31:0] exp);
        begin
            wr_reg(`TSP_A_CTRL, ctrl);
            rd_reg(`TSP_A_COUNT, v);
            repeat (6) @(posedge clk);
            rd_reg(`TSP_A_COUNT, u);
            check("count gap", (u - v) & 32'HFFFF, exp);
        end
    endtask
    // block 2 counts rises of the clock pin, divided by two
    task t_ext;
        begin
            wr_reg(`TSP_A_CB1 + 8'H04, 32'H101);
            wr_reg(`TSP_A_CTRL, 32'H803);
            rd_reg(`TSP_A_COUNT, v);
            for (i = 0; i < 16; i = i + 1) begin
                @(posedge clk);
                ext_clk <= ~ext_clk;
            end
            rd_reg(`TSP_A_COUNT, u);
            check("ext count", (u - v) & 32'HFFFF, 32'H4);
        end
    endtask
    task t_out(input [31:0] ctrl, input [31:0] d, input [31:0] eo, input [31:0] ee, input sb);
        begin
            wr_reg(`TSP_A_CTRL, ctrl);
            wr_reg(`TSP_A_DATA, d);
            wait_evt(8);
            check("pin drive", pin_out_r, eo);
            check("pin enable", pin_oe_r, ee);
            check("out strobe", output_strobe_r, sb);
        end
    endtask
    task t_timed;
        begin
            wr_reg(`TSP_A_CTRL, 32'H23);
            rd_reg(`TSP_A_COUNT, v);
            wr_reg(`TSP_A_TIME, (v + 32'H1E) & 32'HFFFF);
            wr_reg(`TSP_A_DATA, 32'H5AA5F00F);
            wait_evt(60);
            check("held till time", n > 12, 1'b1);
            check("timed data", pin_out_r, 32'H5AA5F00F);
            rd_reg(`TSP_A_TSTAMP, u);
            check("timestamp", u, (v + 32'H1E) & 32'HFFFF);
        end
    endtask
    // nibbles leave low slice first, one per clock
    task t_slices;
        begin
            wr_reg(`TSP_A_CTRL, 32'HB);
            wr_reg(`TSP_A_DATA, 32'H87654321);
            n = 0;
            while (pin_out_r[3:0] !== 4'H1 && n < 8) begin
                @(posedge clk);
                #1;
                n = n + 1;
            end
            if (pin_out_r[3:0] !== 4'H1) begin
                miscompares = miscompares + 1;
                test_done;
            end
            for (i = 0; i < 8; i = i + 1) begin
                check("nibble", pin_out_r[3:0], (32'H87654321 >> (4 * i)) & 32'HF);
                @(posedge clk);
                #1;
            end
            check("narrow oe", pin_oe_r, 32'HF);
            @(posedge clk);
            pin_taken <= 32'H6;
            @(posedge clk);
            #1;
            check("taken oe", pin_oe_r, 32'H9);
            @(posedge clk);
            link_en <= 1'b1;
            @(posedge clk);
            #1;
            check("link oe", pin_oe_r, 32'H0);
            @(posedge clk);
            link_en <= 1'b0;
            pin_taken <= 32'H0;
        end
    endtask
    task t_in;
        begin
            wr_reg(`TSP_A_CTRL, 32'H0);
            drv_en <= 32'HFFFFFFFF;
            drv_val <= 32'HA5;
            wr_reg(`TSP_A_CTRL, 32'H11);
            wait_evt(12);
            rd_reg(`TSP_A_DATA, v);
            check("in word", v, 32'HA5A5A5A5);
            @(posedge clk);
            pin_taken <= 32'HF0;
            wait_evt(12);
            wait_evt(12);
            rd_reg(`TSP_A_DATA, v);
            check("taken bits", v, 32'H05050505);
            @(posedge clk);
            link_en <= 1'b1;
            wait_evt(12);
            wait_evt(12);
            rd_reg(`TSP_A_DATA, v);
            check("link word", v, 32'H0);
            rd_reg(`TSP_A_STS, v);
            check("overrun", v[1], 1'b1);
            @(posedge clk);
            link_en <= 1'b0;
            pin_taken <= 32'H0;
        end
    endtask
    // condition start raises status and the masked irq
    task t_cond(input [31:0] ctrl, input [31:0] idle, input [31:0] hit);
        begin
            wr_reg(`TSP_A_CTRL, 32'H0);
            wr_reg(`TSP_A_COND, 32'H3C);
            wr_reg(`TSP_A_STS, 32'H7);
            wr_reg(`TSP_A_MASK, 32'H4);
            drv_val <= idle;
            wr_reg(`TSP_A_CTRL, ctrl);
            repeat (10) @(posedge clk);
            rd_reg(`TSP_A_STS, v);
            check("held off", v[2], 1'b0);
            check("irq idle", irq_r, 1'b0);
            @(posedge clk);
            drv_val <= hit;
            wait_evt(12);
            repeat (2) @(posedge clk);
            #1;
            check("irq up", irq_r, 1'b1);
            rd_reg(`TSP_A_STS, v);
            check("cond start", v[2], 1'b1);
            wr_reg(`TSP_A_CTRL, 32'H0);
            wr_reg(`TSP_A_STS, 32'H4);
            repeat (2) @(posedge clk);
            #1;
            check("irq clear", irq_r, 1'b0);
        end
    endtask
    task t_strobe;
        begin
            @(posedge clk);
            drv_val <= 32'H5A;
            drv_strobe <= 1'b0;
            wr_reg(`TSP_A_CTRL, 32'H111);
            wr_reg(`TSP_A_STS, 32'H7);
            repeat (12) @(posedge clk);
            rd_reg(`TSP_A_STS, v);
            check("no strobe", v[0], 1'b0);
            @(posedge clk);
            drv_strobe <= 1'b1;
            wait_evt(12);
            rd_reg(`TSP_A_DATA, v);
            check("strobed", v, 32'H5A5A5A5A);
        end
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_rate(32'H3, 32'H8);
        rd2;
        check("count step", (u - v) & 32'HFFFF, 32'H1);
        wr_reg(`TSP_A_CB1, 32'H3);
        rd_reg(`TSP_A_CB1, v);
        check("cb1 cfg", v, 32'H3);
        t_rate(32'H403, 32'H2);
        t_rate(32'H1803, 32'H8);
        t_ext;
        t_out(32'H223, 32'HC3A51E69, 32'HC3A51E69, 32'HFFFFFFFF, 1'b1);
        t_out(32'H27, 32'H0000FFFF, 32'H0, 32'HFFFF0000, 1'b0);
        t_timed;
        t_slices;
        t_in;
        t_cond(32'H51, 32'H0, 32'H3C);
        t_cond(32'H91, 32'H3C, 32'H0);
        t_strobe;
        test_done;
    end
    // hang guard
    initial begin
        #3000000;
        miscompares = miscompares + 1;
        test_done;
    end
endmodule
bind tsp_port tsp_port_chk tsp_port_chk_inst (.clk(clk), .rst(rst), .addr(addr), .wr(wr), .rd(rd),
    .rdata_r(rdata_r), .pin_oe_r(pin_oe_r), .pin_taken(pin_taken), .link_en(link_en),
    .output_strobe_r(output_strobe_r), .event_r(event_r), .irq_r(irq_r));
